/* hw/pfsr_pkg.sv */
package pfsr_pkg;

   // Five byte-wide status registers, addressed by consecutive codes
   localparam int NUM_REGS = 5;
   localparam int IDX_VOUT = 0;
   localparam int IDX_IOUT = 1;
   localparam int IDX_INPUT = 2;
   localparam int IDX_TEMP = 3;
   localparam int IDX_CML = 4;
   localparam logic [7:0] CODE_VOUT = 8'h7A;
   localparam logic [7:0] CODE_IOUT = 8'h7B;
   localparam logic [7:0] CODE_INPUT = 8'h7C;
   localparam logic [7:0] CODE_TEMP = 8'h7D;
   localparam logic [7:0] CODE_CML = 8'h7E;

   // Field positions
   localparam int BIT_OVF = 7;
   localparam int BIT_OVW = 6;
   localparam int BIT_UVW = 5;
   localparam int BIT_UVF = 4;
   localparam int BIT_SETPT = 3;
   localparam int BIT_TONMAX = 2;
   localparam int BIT_OCF = 7;
   localparam int BIT_OCW = 5;
   localparam int BIT_LOWVIN = 3;
   localparam int BIT_OTF = 7;
   localparam int BIT_OTW = 6;
   localparam int BIT_IVC = 7;
   localparam int BIT_IVD = 6;
   localparam int BIT_PEC = 5;
   localparam int BIT_MEM = 4;
   localparam int BIT_OTH = 1;

   typedef logic [NUM_REGS-1:0][7:0] pfsr_bank_type;

   // Writable (clearable) bits; every other bit reads zero
   localparam pfsr_bank_type WMASK_C = {8'hF2, 8'hC0, 8'h08, 8'hA0, 8'hFC};
   localparam pfsr_bank_type RESET_C = {8'h00, 8'h00, 8'h08, 8'h00, 8'h00};
   // Low-input bit, held off the alert line until input first comes up
   localparam pfsr_bank_type LOWVIN_GATE_C =
      {8'h00, 8'h00, 8'h08, 8'h00, 8'h00};

   // Temperature re-set band after a host clear, in degrees C
   localparam logic signed [15:0] OT_HYST_C = 16'sh0014;

   typedef struct packed {
      logic valid;
      logic write;
      logic [7:0] code;
      logic [7:0] wdata;
   } pfsr_cmd_type;

   typedef struct packed {
      logic ov_fault;
      logic ov_warn;
      logic uv_warn;
      logic uv_fault;
      logic oc_fault;
      logic oc_warn;
      logic vin_on;
      logic vin_off;
   } pfsr_cmp_type;

   typedef struct packed {
      logic setpoint_range;
      logic ton_max;
      logic inv_cmd;
      logic inv_data;
      logic pec_fail;
      logic mem_fault;
      logic other_comm;
   } pfsr_evt_type;

   typedef struct packed {
      logic vout_over_fault;
      logic overcurrent_fault;
      logic vout_any;
      logic iout_any;
      logic input_any;
      logic temp_any;
      logic cml_any;
   } pfsr_summary_type;

endpackage

/* hw/pfsr_sync3.sv */
`timescale 1ns/1ps
module pfsr_sync3 #(
   parameter int WIDTH = 8
) (
   input wire logic sys_clk_i,
   input wire logic rst_i,
   input wire logic [WIDTH-1:0] async_i,
   output logic [WIDTH-1:0] sync_o
);
   logic [WIDTH-1:0] s1_reg;
   logic [WIDTH-1:0] s2_reg;
   logic [WIDTH-1:0] s3_reg;
   logic [WIDTH-1:0] out_reg;
   logic [WIDTH-1:0] out_next;

   // A bit changes only once the second and third stages agree
   assign out_next = (s2_reg & ~(s2_reg ^ s3_reg)) |
                     (out_reg & (s2_reg ^ s3_reg));
   assign sync_o = out_reg;

   always_ff @(posedge sys_clk_i or posedge rst_i) begin
      if (rst_i) begin
         s1_reg <= '0;
         s2_reg <= '0;
         s3_reg <= '0;
         out_reg <= '0;
      end else begin
         s1_reg <= async_i;
         s2_reg <= s1_reg;
         s3_reg <= s2_reg;
         out_reg <= out_next;
      end
   end
endmodule

/* hw/pfsr_flag_byte.sv */
`timescale 1ns/1ps
module pfsr_flag_byte #(
   parameter logic [7:0] WMASK = 8'hFF,
   parameter logic [7:0] RESET_VAL = 8'h00
) (
   input wire logic sys_clk_i,
   input wire logic rst_i,
   input wire logic [7:0] set_i,
   input wire logic [7:0] clr_i,
   input wire logic force_zero_i,
   output logic [7:0] flags_o
);
   logic [7:0] flags_reg;
   logic [7:0] flags_next;

   // Set wins over a clear in the same cycle
   assign flags_next = force_zero_i ? 8'h00 :
                       (((flags_reg & ~clr_i) | set_i) & WMASK);
   assign flags_o = flags_reg;

   always_ff @(posedge sys_clk_i or posedge rst_i) begin
      if (rst_i) begin
         flags_reg <= RESET_VAL;
      end else begin
         flags_reg <= flags_next;
      end
   end
endmodule

/* hw/pfsr_status_bank.sv */
`timescale 1ns/1ps
module pfsr_status_bank (
   input wire logic sys_clk_i,
   input wire logic rst_i,
   input wire pfsr_pkg::pfsr_cmd_type cmd_i,
   output logic [7:0] rd_data_o,
   output logic rd_valid_o,
   input wire pfsr_pkg::pfsr_cmp_type cmp_async_i,
   input wire pfsr_pkg::pfsr_evt_type evt_i,
   input wire logic signed [15:0] temp_i,
   input wire logic signed [15:0] ot_fault_limit_i,
   input wire logic signed [15:0] ot_warn_limit_i,
   input wire logic loop_slave_i,
   input wire pfsr_pkg::pfsr_bank_type alert_mask_i,
   output pfsr_pkg::pfsr_bank_type status_o,
   output pfsr_pkg::pfsr_summary_type summary_o,
   output logic smbalert_drv_o,
   output logic smbalert_oe_o
);
   logic [7:0] cmp_raw;
   pfsr_pkg::pfsr_cmp_type cmp_s;
   pfsr_pkg::pfsr_bank_type flags;
   pfsr_pkg::pfsr_bank_type set_bank;
   pfsr_pkg::pfsr_bank_type clr_bank;
   pfsr_pkg::pfsr_bank_type host_clr;
   pfsr_pkg::pfsr_bank_type alert_gate;
   pfsr_pkg::pfsr_summary_type summary_reg;
   pfsr_pkg::pfsr_summary_type summary_next;
   logic [7:0] rd_data_reg;
   logic [7:0] rd_data_next;
   logic rd_valid_reg;
   logic vin_seen_reg;
   logic vin_seen_next;
   logic alert_reg;
   logic alert_next;
   logic code_hit;
   logic wr_hit;
   logic [2:0] sel;
   logic [7:0] code_off;
   logic signed [15:0] otf_band;
   logic signed [15:0] otw_band;

   // Comparator outputs come from the analog side
   assign cmp_raw = cmp_async_i;

   pfsr_sync3 #(
      .WIDTH(8)
   ) u_cmp_sync (
      .sys_clk_i(sys_clk_i),
      .rst_i(rst_i),
      .async_i(cmp_raw),
      .sync_o(cmp_s)
   );

   // Command decode over the five consecutive codes
   assign code_off = cmd_i.code - pfsr_pkg::CODE_VOUT;
   assign code_hit = (cmd_i.code >= pfsr_pkg::CODE_VOUT) &&
                     (cmd_i.code <= pfsr_pkg::CODE_CML);
   assign sel = code_off[2:0];
   assign wr_hit = cmd_i.valid && cmd_i.write && code_hit;

   assign otf_band = ot_fault_limit_i - pfsr_pkg::OT_HYST_C;
   assign otw_band = ot_warn_limit_i - pfsr_pkg::OT_HYST_C;

   always_comb begin
      set_bank = '0;
      // Output voltage flags
      set_bank[pfsr_pkg::IDX_VOUT][pfsr_pkg::BIT_OVF] = cmp_s.ov_fault;
      set_bank[pfsr_pkg::IDX_VOUT][pfsr_pkg::BIT_OVW] = cmp_s.ov_warn;
      set_bank[pfsr_pkg::IDX_VOUT][pfsr_pkg::BIT_UVW] = cmp_s.uv_warn;
      set_bank[pfsr_pkg::IDX_VOUT][pfsr_pkg::BIT_UVF] = cmp_s.uv_fault;
      set_bank[pfsr_pkg::IDX_VOUT][pfsr_pkg::BIT_SETPT] =
         evt_i.setpoint_range;
      set_bank[pfsr_pkg::IDX_VOUT][pfsr_pkg::BIT_TONMAX] = evt_i.ton_max;
      // Output current flags
      set_bank[pfsr_pkg::IDX_IOUT][pfsr_pkg::BIT_OCF] = cmp_s.oc_fault;
      set_bank[pfsr_pkg::IDX_IOUT][pfsr_pkg::BIT_OCW] = cmp_s.oc_warn;
      // Live before first turn-on, latched on turn-off afterwards
      set_bank[pfsr_pkg::IDX_INPUT][pfsr_pkg::BIT_LOWVIN] = vin_seen_reg ?
         cmp_s.vin_off : !cmp_s.vin_on;
      // A host clear re-sets unless 20 C below the limit
      set_bank[pfsr_pkg::IDX_TEMP][pfsr_pkg::BIT_OTF] =
         (temp_i >= ot_fault_limit_i) ||
         (host_clr[pfsr_pkg::IDX_TEMP][pfsr_pkg::BIT_OTF] &&
          (temp_i > otf_band));
      set_bank[pfsr_pkg::IDX_TEMP][pfsr_pkg::BIT_OTW] =
         (temp_i >= ot_warn_limit_i) ||
         (host_clr[pfsr_pkg::IDX_TEMP][pfsr_pkg::BIT_OTW] &&
          (temp_i > otw_band));
      // Communication and memory flags
      set_bank[pfsr_pkg::IDX_CML][pfsr_pkg::BIT_IVC] = evt_i.inv_cmd;
      set_bank[pfsr_pkg::IDX_CML][pfsr_pkg::BIT_IVD] = evt_i.inv_data;
      set_bank[pfsr_pkg::IDX_CML][pfsr_pkg::BIT_PEC] = evt_i.pec_fail;
      set_bank[pfsr_pkg::IDX_CML][pfsr_pkg::BIT_MEM] = evt_i.mem_fault;
      set_bank[pfsr_pkg::IDX_CML][pfsr_pkg::BIT_OTH] = evt_i.other_comm;
   end

   genvar g;
   generate
      for (g = 0; g < pfsr_pkg::NUM_REGS; g = g + 1) begin : g_reg
         // Only bits written as one are cleared
         assign host_clr[g] = (wr_hit && (sel == 3'(g))) ?
                              cmd_i.wdata : 8'h00;
         if (g == pfsr_pkg::IDX_INPUT) begin : g_in
            // Before first turn-on the bit tracks the input, not the host
            assign clr_bank[g] = vin_seen_reg ? host_clr[g] :
               ({7'h00, cmp_s.vin_on} << pfsr_pkg::BIT_LOWVIN);
         end else begin : g_other
            assign clr_bank[g] = host_clr[g];
         end
         pfsr_flag_byte #(
            .WMASK(pfsr_pkg::WMASK_C[g]),
            .RESET_VAL(pfsr_pkg::RESET_C[g])
         ) u_flags (
            .sys_clk_i(sys_clk_i),
            .rst_i(rst_i),
            .set_i(set_bank[g]),
            .clr_i(clr_bank[g]),
            .force_zero_i(loop_slave_i && (g == pfsr_pkg::IDX_VOUT)),
            .flags_o(flags[g])
         );
      end
   endgenerate

   assign vin_seen_next = vin_seen_reg || cmp_s.vin_on;

   // Low-input bit stays off the alert during the initial phase
   assign alert_gate = vin_seen_reg ? '1 : ~pfsr_pkg::LOWVIN_GATE_C;
   assign alert_next = |(flags & ~alert_mask_i & alert_gate);

   // Summary bits are derived only; no write reaches them
   assign summary_next.vout_over_fault =
      flags[pfsr_pkg::IDX_VOUT][pfsr_pkg::BIT_OVF];
   assign summary_next.overcurrent_fault =
      flags[pfsr_pkg::IDX_IOUT][pfsr_pkg::BIT_OCF];
   assign summary_next.vout_any = |flags[pfsr_pkg::IDX_VOUT];
   assign summary_next.iout_any = |flags[pfsr_pkg::IDX_IOUT];
   assign summary_next.input_any = |flags[pfsr_pkg::IDX_INPUT];
   assign summary_next.temp_any = |flags[pfsr_pkg::IDX_TEMP];
   assign summary_next.cml_any = |flags[pfsr_pkg::IDX_CML];

   // Unmapped codes read as zero; unused bits already read zero
   assign rd_data_next = code_hit ? flags[sel] : 8'h00;

   always_ff @(posedge sys_clk_i or posedge rst_i) begin
      if (rst_i) begin
         vin_seen_reg <= 1'b0;
         alert_reg <= 1'b0;
         summary_reg <= '0;
         rd_data_reg <= 8'h00;
         rd_valid_reg <= 1'b0;
      end else begin
         vin_seen_reg <= vin_seen_next;
         alert_reg <= alert_next;
         summary_reg <= summary_next;
         rd_data_reg <= (cmd_i.valid && !cmd_i.write) ? rd_data_next :
                        rd_data_reg;
         rd_valid_reg <= cmd_i.valid && !cmd_i.write;
      end
   end

   assign status_o = flags;
   assign summary_o = summary_reg;
   assign rd_data_o = rd_data_reg;
   assign rd_valid_o = rd_valid_reg;
   // Open-drain alert: pulls low when enabled
   assign smbalert_drv_o = 1'b0;
   assign smbalert_oe_o = alert_reg;

   default clocking cb @(posedge sys_clk_i);
   endclocking
   default disable iff (rst_i);

   chk_vout_read_fmt: assert property (
      (cmd_i.valid && !cmd_i.write && cmd_i.code == pfsr_pkg::CODE_VOUT)
      |=> rd_valid_o && rd_data_o[1:0] == 2'h0 &&
          rd_data_o == $past(flags[pfsr_pkg::IDX_VOUT]))
      else $error("vout status read returned wrong byte");

   chk_ovf_sets: assert property (
      (cmp_s.ov_fault && !loop_slave_i)
      |=> flags[pfsr_pkg::IDX_VOUT][pfsr_pkg::BIT_OVF])
      else $error("overvoltage fault flag not set");

   chk_slave_zero: assert property (
      loop_slave_i |=> flags[pfsr_pkg::IDX_VOUT] == 8'h00)
      else $error("vout flags not forced to zero on loop slave");

   chk_host_clear: assert property (
      (wr_hit && sel == 3'(pfsr_pkg::IDX_CML) &&
       cmd_i.wdata[pfsr_pkg::BIT_PEC] && !evt_i.pec_fail)
      |=> !flags[pfsr_pkg::IDX_CML][pfsr_pkg::BIT_PEC])
      else $error("packet error flag not cleared by host write");

   chk_clear_only_ones: assert property (
      (wr_hit && sel == 3'(pfsr_pkg::IDX_IOUT) &&
       !cmd_i.wdata[pfsr_pkg::BIT_OCW] &&
       flags[pfsr_pkg::IDX_IOUT][pfsr_pkg::BIT_OCW])
      |=> flags[pfsr_pkg::IDX_IOUT][pfsr_pkg::BIT_OCW])
      else $error("flag written with zero was cleared");

   chk_lowvin_live: assert property (
      (!vin_seen_reg && !cmp_s.vin_on)
      |=> flags[pfsr_pkg::IDX_INPUT][pfsr_pkg::BIT_LOWVIN])
      else $error("low-input flag dropped before first turn-on");

   chk_lowvin_latch: assert property (
      (vin_seen_reg && cmp_s.vin_off)
      |=> flags[pfsr_pkg::IDX_INPUT][pfsr_pkg::BIT_LOWVIN] [*2])
      else $error("low-input flag not latched after turn-off");

   chk_ot_hyst: assert property (
      (host_clr[pfsr_pkg::IDX_TEMP][pfsr_pkg::BIT_OTF] &&
       temp_i > otf_band)
      |=> flags[pfsr_pkg::IDX_TEMP][pfsr_pkg::BIT_OTF])
      else $error("over-temperature flag cleared inside 20 C band");

   chk_alert_follow: assert property (
      $rose(|(flags & ~alert_mask_i & alert_gate)) |=> smbalert_oe_o)
      else $error("alert not raised for unmasked flag");

   chk_alert_release: assert property (
      (flags & ~alert_mask_i & alert_gate) == '0 |=> !smbalert_oe_o)
      else $error("alert held with no unmasked flag");

   chk_summary_follow: assert property (
      summary_o.vout_over_fault ==
      $past(flags[pfsr_pkg::IDX_VOUT][pfsr_pkg::BIT_OVF]))
      else $error("summary bit does not follow vout flag");

   chk_ovw_sets: assert property (
      (cmp_s.ov_warn && !loop_slave_i)
      |=> flags[pfsr_pkg::IDX_VOUT][pfsr_pkg::BIT_OVW])
      else $error("overvoltage warning flag not set");

   chk_uvw_sets: assert property (
      (cmp_s.uv_warn && !loop_slave_i)
      |=> flags[pfsr_pkg::IDX_VOUT][pfsr_pkg::BIT_UVW])
      else $error("undervoltage warning flag not set");

   chk_uvf_sets: assert property (
      (cmp_s.uv_fault && !loop_slave_i)
      |=> flags[pfsr_pkg::IDX_VOUT][pfsr_pkg::BIT_UVF])
      else $error("undervoltage fault flag not set");

   chk_setpt_sets: assert property (
      (evt_i.setpoint_range && !loop_slave_i)
      |=> flags[pfsr_pkg::IDX_VOUT][pfsr_pkg::BIT_SETPT])
      else $error("setpoint range flag not set");

   chk_ocf_sets: assert property (
      cmp_s.oc_fault
      |=> flags[pfsr_pkg::IDX_IOUT][pfsr_pkg::BIT_OCF])
      else $error("overcurrent fault flag not set");

   chk_ocw_sets: assert property (
      cmp_s.oc_warn
      |=> flags[pfsr_pkg::IDX_IOUT][pfsr_pkg::BIT_OCW])
      else $error("overcurrent warning flag not set");

   chk_iout_unused: assert property (
      (flags[pfsr_pkg::IDX_IOUT] & 8'h5F) == 8'h00)
      else $error("unused current status bit set");

   chk_input_unused: assert property (
      (flags[pfsr_pkg::IDX_INPUT] & 8'hF7) == 8'h00)
      else $error("unused input status bit set");

   chk_temp_unused: assert property (
      (flags[pfsr_pkg::IDX_TEMP] & 8'h3F) == 8'h00)
      else $error("unused temperature status bit set");

   chk_cml_unused: assert property (
      (flags[pfsr_pkg::IDX_CML] & 8'h0D) == 8'h00)
      else $error("unused communication status bit set");

   chk_otf_sets: assert property (
      temp_i >= ot_fault_limit_i
      |=> flags[pfsr_pkg::IDX_TEMP][pfsr_pkg::BIT_OTF])
      else $error("over-temperature fault flag not set");

   chk_otw_sets: assert property (
      temp_i >= ot_warn_limit_i
      |=> flags[pfsr_pkg::IDX_TEMP][pfsr_pkg::BIT_OTW])
      else $error("over-temperature warning flag not set");

   chk_ivc_sets: assert property (
      evt_i.inv_cmd
      |=> flags[pfsr_pkg::IDX_CML][pfsr_pkg::BIT_IVC])
      else $error("invalid command flag not set");

   chk_ivd_sets: assert property (
      evt_i.inv_data
      |=> flags[pfsr_pkg::IDX_CML][pfsr_pkg::BIT_IVD])
      else $error("invalid data flag not set");

   chk_pec_sets: assert property (
      evt_i.pec_fail
      |=> flags[pfsr_pkg::IDX_CML][pfsr_pkg::BIT_PEC])
      else $error("packet error flag not set");

   chk_mem_sets: assert property (
      evt_i.mem_fault
      |=> flags[pfsr_pkg::IDX_CML][pfsr_pkg::BIT_MEM])
      else $error("memory fault flag not set");

   chk_oth_sets: assert property (
      evt_i.other_comm
      |=> flags[pfsr_pkg::IDX_CML][pfsr_pkg::BIT_OTH])
      else $error("other communication flag not set");

   chk_read_valid: assert property (
      (cmd_i.valid && !cmd_i.write) |=> rd_valid_o)
      else $error("read answered without valid pulse");
endmodule

/* sim/pfsr_host_model.sv */
`timescale 1ns/1ps
module pfsr_host_model (
   input wire logic sys_clk_i,
   input wire logic [7:0] rd_data_i,
   input wire logic rd_valid_i,
   output pfsr_pkg::pfsr_cmd_type cmd_o
);
   initial begin
      cmd_o = '0;
   end

   // Valid is held for one taking edge only; released fields are inverted
   // so that nothing downstream can lean on stale command bytes
   task automatic issue(input logic w, input logic [7:0] code, wdata);
      @(posedge sys_clk_i);
      cmd_o <= '{valid: 1'b1, write: w, code: code, wdata: wdata};
      @(posedge sys_clk_i);
      cmd_o <= '{valid: 1'b0, write: ~w, code: ~code, wdata: ~wdata};
   endtask

   // Written ones clear flags, zeros leave them alone
   task automatic wr(input logic [7:0] code, wdata);
      issue(1'b1, code, wdata);
   endtask

   // Read byte is taken at the edge where the valid pulse is seen
   task automatic rd(input logic [7:0] code, output logic [7:0] data);
      int n;
      data = 'x;
      issue(1'b0, code, 8'h00);
      for (n = 0; n < 3; n++) begin
         @(posedge sys_clk_i);
         if (rd_valid_i === 1'b1) begin
            data = rd_data_i;
            n = 3;
         end
      end
   endtask
endmodule

/* sim/tb.sv */
`timescale 1ns/1ps
module tb;
   logic sys_clk_i;
   logic rst_i;
   pfsr_pkg::pfsr_cmd_type cmd;
   pfsr_pkg::pfsr_cmp_type cmp;
   pfsr_pkg::pfsr_evt_type evt;
   logic signed [15:0] temp;
   logic signed [15:0] otf_lim;
   logic signed [15:0] otw_lim;
   logic slave;
   pfsr_pkg::pfsr_bank_type mask;
   pfsr_pkg::pfsr_bank_type status;
   pfsr_pkg::pfsr_summary_type summary;
   logic [7:0] rd_data;
   logic rd_valid;
   logic alert_drv;
   logic alert;
   logic [7:0] d;
   int n_fail;
   int checked;
   int cycles;
   localparam logic [7:0] CODE_T [13] = '{8'h7A, 8'h7A, 8'h7A, 8'h7A,
      8'h7B, 8'h7B, 8'h7A, 8'h7A, 8'h7E, 8'h7E, 8'h7E, 8'h7E, 8'h7E};
   localparam logic [7:0] BIT_T [13] = '{8'h80, 8'h40, 8'h20, 8'h10,
      8'h80, 8'h20, 8'h08, 8'h04, 8'h80, 8'h40, 8'h20, 8'h10, 8'h02};
   localparam logic [7:0] RST_T [5] = '{8'h00, 8'h00, 8'h08, 8'h00, 8'h00};

   pfsr_status_bank pfsr_status_bank_i (
      .sys_clk_i(sys_clk_i), .rst_i(rst_i), .cmd_i(cmd),
      .rd_data_o(rd_data), .rd_valid_o(rd_valid), .cmp_async_i(cmp),
      .evt_i(evt), .temp_i(temp), .ot_fault_limit_i(otf_lim),
      .ot_warn_limit_i(otw_lim), .loop_slave_i(slave),
      .alert_mask_i(mask), .status_o(status), .summary_o(summary),
      .smbalert_drv_o(alert_drv), .smbalert_oe_o(alert)
   );

   pfsr_host_model pfsr_host_model_i (
      .sys_clk_i(sys_clk_i), .rd_data_i(rd_data), .rd_valid_i(rd_valid),
      .cmd_o(cmd)
   );

   initial begin
      sys_clk_i = 1'b0;
      forever #2 sys_clk_i = ~sys_clk_i;
   end

   task automatic cyc(input int n);
      repeat (n) @(posedge sys_clk_i);
   endtask

   task automatic chk(input logic [7:0] got, exp);
      checked++;
      if (got !== exp) begin
         n_fail++;
         $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   task automatic rdchk(input logic [7:0] code, exp);
      logic [7:0] v;
      pfsr_host_model_i.rd(code, v);
      chk(v, exp);
   endtask

   task automatic test_done;
      $display("checks=%0d mismatches=%0d", checked, n_fail);
      if (n_fail == 0 && checked > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask

   always @(posedge sys_clk_i) begin
      cycles++;
      if (cycles == 20000) begin
         n_fail++;
         test_done;
      end
   end

   initial begin
      rst_i = 1'b1;
      cmp = '0;
      evt = '0;
      temp = 16'sh0019;
      otf_lim = 16'sh0064;
      otw_lim = 16'sh005A;
      slave = 1'b0;
      mask = '0;
      n_fail = 0;
      checked = 0;
      cycles = 0;
      cyc(5);
      rst_i <= 1'b0;
      // Reset values, unmapped codes, early low-input byte
      for (int i = 0; i < 5; i++) rdchk(8'h7A + 8'(i), RST_T[i]);
      rdchk(8'h7F, 8'h00);
      rdchk(8'h79, 8'h00);
      chk(status[2], 8'h08);
      chk({1'b0, summary}, 8'h04);
      chk({7'h00, alert}, 8'h00);
      // Every output-voltage, output-current and CML flag source: set, alert, partial clear, full clear
      for (int k = 0; k < 13; k++) begin
         if (k < 6) begin
            cmp <= pfsr_pkg::pfsr_cmp_type'(8'h80 >> k);
            cyc(8);
            cmp <= '0;
         end else begin
            cyc(1);
            evt <= pfsr_pkg::pfsr_evt_type'(7'h40 >> (k - 6));
            cyc(1);
            evt <= '0;
         end
         cyc(8);
         rdchk(CODE_T[k], BIT_T[k]);
         chk({7'h00, alert}, 8'h01);
         pfsr_host_model_i.wr(CODE_T[k], ~BIT_T[k]);
         rdchk(CODE_T[k], BIT_T[k]);
         pfsr_host_model_i.wr(CODE_T[k], BIT_T[k]);
         cyc(3);
         rdchk(CODE_T[k], 8'h00);
         chk({7'h00, alert}, 8'h00);
      end
      // Masked flag latches but stays off the alert line
      mask[4] <= 8'h80;
      cyc(1);
      evt.inv_cmd <= 1'b1;
      cyc(1);
      evt.inv_cmd <= 1'b0;
      cyc(4);
      rdchk(8'h7E, 8'h80);
      chk({7'h00, alert}, 8'h00);
      pfsr_host_model_i.wr(8'h7E, 8'h80);
      mask[4] <= 8'h00;
      // Loop slave empties the output-voltage byte
      cmp.ov_fault <= 1'b1;
      cyc(8);
      slave <= 1'b1;
      cyc(3);
      rdchk(8'h7A, 8'h00);
      cmp.ov_fault <= 1'b0;
      slave <= 1'b0;
      cyc(8);
      pfsr_host_model_i.wr(8'h7A, 8'hFF);
      // Temperature limits and the 20 degree re-set band
      temp <= 16'sh0064;
      cyc(3);
      rdchk(8'h7D, 8'hC0);
      temp <= 16'sh0051;
      pfsr_host_model_i.wr(8'h7D, 8'hC0);
      cyc(3);
      rdchk(8'h7D, 8'hC0);
      temp <= 16'sh0046;
      pfsr_host_model_i.wr(8'h7D, 8'hC0);
      cyc(3);
      rdchk(8'h7D, 8'h00);
      temp <= 16'sh005A;
      cyc(3);
      rdchk(8'h7D, 8'h40);
      temp <= 16'sh0019;
      pfsr_host_model_i.wr(8'h7D, 8'h40);
      cyc(3);
      // Low input: live before first turn-on, latched and alerting after
      pfsr_host_model_i.wr(8'h7C, 8'h08);
      rdchk(8'h7C, 8'h08);
      cmp.vin_on <= 1'b1;
      cyc(8);
      rdchk(8'h7C, 8'h00);
      cmp.vin_on <= 1'b0;
      cmp.vin_off <= 1'b1;
      cyc(8);
      cmp.vin_off <= 1'b0;
      cyc(8);
      rdchk(8'h7C, 8'h08);
      chk({7'h00, alert}, 8'h01);
      pfsr_host_model_i.wr(8'h7C, 8'h08);
      cyc(3);
      rdchk(8'h7C, 8'h00);
      chk({7'h00, alert}, 8'h00);
      chk({7'h00, alert_drv}, 8'h00);
      chk({1'b0, summary}, 8'h00);
      test_done;
   end
endmodule
